// File: cddc_consts.svh
// constants for the channel and converter configuration register bank
`ifndef CDDC_CONSTS_SVH
`define CDDC_CONSTS_SVH

// byte addresses: printed offsets are not all multiples of four, so address = 4 * index
`define CDDC_IDX_OVR_HI 8'h07
`define CDDC_IDX_OVR_LO 8'h08
`define CDDC_IDX_NYQ 8'h2d
`define CDDC_IDX_MIXBAND 8'h78
`define CDDC_IDX_WORD_HI 8'h7a
`define CDDC_IDX_WORD_LO 8'h7b
`define CDDC_IDX_LOSS 8'h7e
`define CDDC_IDX_CAL 8'hd5
`define CDDC_IDX_PAGE 8'hf0

`define CDDC_RST_OVR_HI 8'hff
`define CDDC_RST_OVR_LO 8'h00
`define CDDC_RST_NYQ 8'h00
`define CDDC_RST_MIXBAND 8'h00
`define CDDC_RST_WORD 8'h00
`define CDDC_RST_LOSS 8'h03
`define CDDC_RST_CAL 8'h00
`define CDDC_RST_PAGE 8'h00

// writable bit masks, reserved bits stay zero
`define CDDC_MSK_NYQ 8'h02
`define CDDC_MSK_MIXBAND 8'h07
`define CDDC_MSK_LOSS 8'h07
`define CDDC_MSK_CAL 8'h08
`define CDDC_MSK_PAGE 8'hff
`define CDDC_MSK_FULL 8'hff

`define CDDC_BIT_NYQ 1
`define CDDC_BIT_PREFILT 0
`define CDDC_BIT_BAND02 1
`define CDDC_BIT_SIGN 2
`define CDDC_BIT_LC13 0
`define CDDC_BIT_LC0 1
`define CDDC_BIT_LC467 2
`define CDDC_BIT_CAL 3

`define CDDC_RESP_OKAY 2'b00
`define CDDC_RESP_SLVERR 2'b10

`endif

// File: cddc_pkg.sv
// types for the channel and converter configuration register bank
package cddc_pkg;
  typedef enum logic [1:0] {
    CDDC_WR_IDLE = 2'b00,
    CDDC_WR_RESP = 2'b01
  } cddc_wr_e;
  typedef enum logic [0:0] {
    CDDC_RD_IDLE = 1'b0,
    CDDC_RD_DATA = 1'b1
  } cddc_rd_e;
endpackage

// File: cddc_reg8.sv
// one 8-bit read-write register with reset value and writable mask
`timescale 1ns/1ps
`default_nettype none
module cddc_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  logic [7:0] value_q;
  wire logic [7:0] value_d = wr_en ? (wr_data & WRITE_MASK) : value_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end
  assign value = value_q;
endmodule
`default_nettype wire

// File: cddc_regs.sv
// per-channel and per-converter configuration registers behind an axi4-lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cddc_consts.svh"

// Functional notes
// - nyquist bit picks zone one or two trims
// - mode zero mixer at minus/plus quarter rate
// - modes zero/two band bit: low/high pass
// - prefilter bit: low-pass or high-pass
// - sixteen-bit oscillator word from two bytes
// - modes four/six/seven gain bit, reset zero
// - mode zero gain bit, reset one
// - modes one/three gain bit, reset one
// - upper overrange limit, reset all ones
// - lower overrange limit, software writable
// - calibration runs while enable bit set
module cddc_regs #(
  parameter int NUM_CH = 4,
  parameter int NUM_ADC = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_CH-1:0] nyquist_zone_two,
  output logic [NUM_CH-1:0] prefilter_band_select,
  output logic [NUM_CH-1:0] band_select_modes_zero_two,
  output logic [NUM_CH-1:0] quarter_rate_mix_sign,
  output logic [16*NUM_CH-1:0] oscillator_frequency_word,
  output logic [NUM_CH-1:0] loss_comp_modes_four_six_seven,
  output logic [NUM_CH-1:0] loss_comp_mode_zero,
  output logic [NUM_CH-1:0] loss_comp_modes_one_three,
  output logic [8*NUM_ADC-1:0] fast_overrange_upper_limit,
  output logic [8*NUM_ADC-1:0] fast_overrange_lower_limit,
  output logic [NUM_ADC-1:0] calibration_run
);

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  cddc_pkg::cddc_wr_e wr_state_q;
  cddc_pkg::cddc_wr_e wr_state_d;
  logic [9:0] awaddr_q;
  logic aw_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic w_held_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire logic aw_take = s_axi_awvalid && awready_q;
  wire logic w_take = s_axi_wvalid && wready_q;
  wire logic aw_have = aw_held_q || aw_take;
  wire logic w_have = w_held_q || w_take;
  wire logic [9:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire logic [7:0] wr_byte = w_held_q ? wdata_q : s_axi_wdata[7:0];
  wire logic wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  wire logic wr_fire = (wr_state_q == cddc_pkg::CDDC_WR_IDLE) && aw_have && w_have;
  wire logic [7:0] wr_idx = wr_addr[9:2];
  wire logic wr_aligned = (wr_addr[1:0] == 2'b00);

  // address decode for writes
  wire logic wsel_ovr_hi = wr_aligned && (wr_idx == `CDDC_IDX_OVR_HI);
  wire logic wsel_ovr_lo = wr_aligned && (wr_idx == `CDDC_IDX_OVR_LO);
  wire logic wsel_nyq = wr_aligned && (wr_idx == `CDDC_IDX_NYQ);
  wire logic wsel_mix = wr_aligned && (wr_idx == `CDDC_IDX_MIXBAND);
  wire logic wsel_whi = wr_aligned && (wr_idx == `CDDC_IDX_WORD_HI);
  wire logic wsel_wlo = wr_aligned && (wr_idx == `CDDC_IDX_WORD_LO);
  wire logic wsel_loss = wr_aligned && (wr_idx == `CDDC_IDX_LOSS);
  wire logic wsel_cal = wr_aligned && (wr_idx == `CDDC_IDX_CAL);
  wire logic wsel_page = wr_aligned && (wr_idx == `CDDC_IDX_PAGE);
  wire logic wr_hit = wsel_ovr_hi || wsel_ovr_lo || wsel_nyq || wsel_mix || wsel_whi || wsel_wlo
                      || wsel_loss || wsel_cal || wsel_page;
  wire logic wr_do = wr_fire && wr_hit && wr_lane0;

  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      cddc_pkg::CDDC_WR_IDLE: begin
        if (wr_fire) begin
          wr_state_d = cddc_pkg::CDDC_WR_RESP;
        end
      end
      cddc_pkg::CDDC_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_d = cddc_pkg::CDDC_WR_IDLE;
        end
      end
      default: begin
        wr_state_d = cddc_pkg::CDDC_WR_IDLE;
      end
    endcase
  end

  wire logic wr_idle_next = (wr_state_d == cddc_pkg::CDDC_WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= cddc_pkg::CDDC_WR_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CDDC_RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      aw_held_q <= aw_have && !wr_fire;
      w_held_q <= w_have && !wr_fire;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      awready_q <= wr_idle_next && !(aw_have && !wr_fire);
      wready_q <= wr_idle_next && !(w_have && !wr_fire);
      bvalid_q <= (wr_state_d == cddc_pkg::CDDC_WR_RESP);
      if (wr_fire) begin
        bresp_q <= wr_hit ? `CDDC_RESP_OKAY : `CDDC_RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // page selection
  // ------------------------------------------------------------
  // low bits pick channel pages, high bits pick converter pages
  logic [7:0] page_sel;
  cddc_reg8 #(.RESET_VALUE(`CDDC_RST_PAGE), .WRITE_MASK(`CDDC_MSK_PAGE)) u_page (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_do && wsel_page),
    .wr_data(wr_byte),
    .value(page_sel)
  );
  wire logic [NUM_CH-1:0] ch_sel = page_sel[NUM_CH-1:0];
  wire logic [NUM_ADC-1:0] adc_sel = {NUM_ADC{page_sel[7]}} | NUM_ADC'(page_sel[6:NUM_CH]);

  // ------------------------------------------------------------
  // channel page copies
  // ------------------------------------------------------------
  logic [8*NUM_CH-1:0] nyq_v;
  logic [8*NUM_CH-1:0] mix_v;
  logic [8*NUM_CH-1:0] whi_v;
  logic [8*NUM_CH-1:0] wlo_v;
  logic [8*NUM_CH-1:0] loss_v;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      // one write lands in every selected copy
      wire logic ch_wr = wr_do && ch_sel[gc];
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_NYQ), .WRITE_MASK(`CDDC_MSK_NYQ)) u_nyq (
        .aclk(aclk), .aresetn(aresetn), .wr_en(ch_wr && wsel_nyq), .wr_data(wr_byte),
        .value(nyq_v[8*gc +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_MIXBAND), .WRITE_MASK(`CDDC_MSK_MIXBAND)) u_mix (
        .aclk(aclk), .aresetn(aresetn), .wr_en(ch_wr && wsel_mix), .wr_data(wr_byte),
        .value(mix_v[8*gc +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_WORD), .WRITE_MASK(`CDDC_MSK_FULL)) u_whi (
        .aclk(aclk), .aresetn(aresetn), .wr_en(ch_wr && wsel_whi), .wr_data(wr_byte),
        .value(whi_v[8*gc +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_WORD), .WRITE_MASK(`CDDC_MSK_FULL)) u_wlo (
        .aclk(aclk), .aresetn(aresetn), .wr_en(ch_wr && wsel_wlo), .wr_data(wr_byte),
        .value(wlo_v[8*gc +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_LOSS), .WRITE_MASK(`CDDC_MSK_LOSS)) u_loss (
        .aclk(aclk), .aresetn(aresetn), .wr_en(ch_wr && wsel_loss), .wr_data(wr_byte),
        .value(loss_v[8*gc +: 8])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // converter page copies
  // ------------------------------------------------------------
  logic [8*NUM_ADC-1:0] ohi_v;
  logic [8*NUM_ADC-1:0] olo_v;
  logic [8*NUM_ADC-1:0] cal_v;

  genvar ga;
  generate
    for (ga = 0; ga < NUM_ADC; ga++) begin : g_adc
      wire logic adc_wr = wr_do && adc_sel[ga];
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_OVR_HI), .WRITE_MASK(`CDDC_MSK_FULL)) u_ohi (
        .aclk(aclk), .aresetn(aresetn), .wr_en(adc_wr && wsel_ovr_hi), .wr_data(wr_byte),
        .value(ohi_v[8*ga +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_OVR_LO), .WRITE_MASK(`CDDC_MSK_FULL)) u_olo (
        .aclk(aclk), .aresetn(aresetn), .wr_en(adc_wr && wsel_ovr_lo), .wr_data(wr_byte),
        .value(olo_v[8*ga +: 8])
      );
      cddc_reg8 #(.RESET_VALUE(`CDDC_RST_CAL), .WRITE_MASK(`CDDC_MSK_CAL)) u_cal (
        .aclk(aclk), .aresetn(aresetn), .wr_en(adc_wr && wsel_cal), .wr_data(wr_byte),
        .value(cal_v[8*ga +: 8])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // control outputs, one flop stage each; the overrange limits come straight from the registers
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] nyq2_q;
  logic [NUM_CH-1:0] prefilt_q;
  logic [NUM_CH-1:0] band02_q;
  logic [NUM_CH-1:0] sign_q;
  logic [16*NUM_CH-1:0] word_q;
  logic [NUM_CH-1:0] lc467_q;
  logic [NUM_CH-1:0] lc0_q;
  logic [NUM_CH-1:0] lc13_q;
  logic [NUM_ADC-1:0] cal_q;

  genvar go;
  generate
    for (go = 0; go < NUM_CH; go++) begin : g_chout
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          nyq2_q[go] <= 1'(`CDDC_RST_NYQ >> `CDDC_BIT_NYQ);
          prefilt_q[go] <= 1'(`CDDC_RST_MIXBAND >> `CDDC_BIT_PREFILT);
          band02_q[go] <= 1'(`CDDC_RST_MIXBAND >> `CDDC_BIT_BAND02);
          sign_q[go] <= 1'(`CDDC_RST_MIXBAND >> `CDDC_BIT_SIGN);
          word_q[16*go +: 16] <= {`CDDC_RST_WORD, `CDDC_RST_WORD};
          lc467_q[go] <= 1'(`CDDC_RST_LOSS >> `CDDC_BIT_LC467);
          lc0_q[go] <= 1'(`CDDC_RST_LOSS >> `CDDC_BIT_LC0);
          lc13_q[go] <= 1'(`CDDC_RST_LOSS >> `CDDC_BIT_LC13);
        end else begin
          nyq2_q[go] <= nyq_v[8*go+`CDDC_BIT_NYQ];
          prefilt_q[go] <= mix_v[8*go+`CDDC_BIT_PREFILT];
          band02_q[go] <= mix_v[8*go+`CDDC_BIT_BAND02];
          sign_q[go] <= mix_v[8*go+`CDDC_BIT_SIGN];
          word_q[16*go +: 16] <= {whi_v[8*go +: 8], wlo_v[8*go +: 8]};
          lc467_q[go] <= loss_v[8*go+`CDDC_BIT_LC467];
          lc0_q[go] <= loss_v[8*go+`CDDC_BIT_LC0];
          lc13_q[go] <= loss_v[8*go+`CDDC_BIT_LC13];
        end
      end
    end
    for (go = 0; go < NUM_ADC; go++) begin : g_adcout
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cal_q[go] <= 1'(`CDDC_RST_CAL >> `CDDC_BIT_CAL);
        end else begin
          cal_q[go] <= cal_v[8*go+`CDDC_BIT_CAL];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  // reads show the lowest-numbered selected copy
  cddc_pkg::cddc_rd_e rd_state_q;
  logic arready_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;
  logic [2:0] ch_pick;
  logic [3:0] adc_pick;

  always_comb begin
    ch_pick = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ch_sel[i]) begin
        ch_pick = 3'(i);
      end
    end
    adc_pick = 4'h0;
    for (int j = NUM_ADC - 1; j >= 0; j--) begin
      if (adc_sel[j]) begin
        adc_pick = 4'(j);
      end
    end
  end

  wire logic ar_take = s_axi_arvalid && arready_q;
  wire logic [7:0] rd_idx = s_axi_araddr[9:2];
  wire logic rd_aligned = (s_axi_araddr[1:0] == 2'b00);
  wire logic rsel_ovr_hi = rd_aligned && (rd_idx == `CDDC_IDX_OVR_HI);
  wire logic rsel_ovr_lo = rd_aligned && (rd_idx == `CDDC_IDX_OVR_LO);
  wire logic rsel_nyq = rd_aligned && (rd_idx == `CDDC_IDX_NYQ);
  wire logic rsel_mix = rd_aligned && (rd_idx == `CDDC_IDX_MIXBAND);
  wire logic rsel_whi = rd_aligned && (rd_idx == `CDDC_IDX_WORD_HI);
  wire logic rsel_wlo = rd_aligned && (rd_idx == `CDDC_IDX_WORD_LO);
  wire logic rsel_loss = rd_aligned && (rd_idx == `CDDC_IDX_LOSS);
  wire logic rsel_cal = rd_aligned && (rd_idx == `CDDC_IDX_CAL);
  wire logic rsel_page = rd_aligned && (rd_idx == `CDDC_IDX_PAGE);
  wire logic rd_hit = rsel_ovr_hi || rsel_ovr_lo || rsel_nyq || rsel_mix || rsel_whi || rsel_wlo
                      || rsel_loss || rsel_cal || rsel_page;
  wire logic [7:0] rd_byte = rsel_ovr_hi ? ohi_v[8*adc_pick +: 8] :
                             rsel_ovr_lo ? olo_v[8*adc_pick +: 8] :
                             rsel_cal ? cal_v[8*adc_pick +: 8] :
                             rsel_nyq ? nyq_v[8*ch_pick +: 8] :
                             rsel_mix ? mix_v[8*ch_pick +: 8] :
                             rsel_whi ? whi_v[8*ch_pick +: 8] :
                             rsel_wlo ? wlo_v[8*ch_pick +: 8] :
                             rsel_loss ? loss_v[8*ch_pick +: 8] :
                             rsel_page ? page_sel : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= cddc_pkg::CDDC_RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `CDDC_RESP_OKAY;
    end else begin
      case (rd_state_q)
        cddc_pkg::CDDC_RD_IDLE: begin
          arready_q <= !ar_take;
          if (ar_take) begin
            rd_state_q <= cddc_pkg::CDDC_RD_DATA;
            rvalid_q <= 1'b1;
            rdata_q <= rd_byte;
            rresp_q <= rd_hit ? `CDDC_RESP_OKAY : `CDDC_RESP_SLVERR;
          end
        end
        cddc_pkg::CDDC_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_q <= cddc_pkg::CDDC_RD_IDLE;
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
          end
        end
        default: begin
          rd_state_q <= cddc_pkg::CDDC_RD_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // port drive
  // ------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;
  assign nyquist_zone_two = nyq2_q;
  assign prefilter_band_select = prefilt_q;
  assign band_select_modes_zero_two = band02_q;
  assign quarter_rate_mix_sign = sign_q;
  assign oscillator_frequency_word = word_q;
  assign loss_comp_modes_four_six_seven = lc467_q;
  assign loss_comp_mode_zero = lc0_q;
  assign loss_comp_modes_one_three = lc13_q;
  assign fast_overrange_upper_limit = ohi_v;
  assign fast_overrange_lower_limit = olo_v;
  assign calibration_run = cal_q;
endmodule
`default_nettype wire

// File: cddc_regs_chk.sv
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module cddc_regs_chk #(
  parameter int NUM_CH = 4,
  parameter int NUM_ADC = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [16*NUM_CH-1:0] oscillator_frequency_word,
  input wire logic [NUM_CH-1:0] loss_comp_modes_four_six_seven,
  input wire logic [NUM_CH-1:0] loss_comp_mode_zero,
  input wire logic [NUM_CH-1:0] loss_comp_modes_one_three,
  input wire logic [8*NUM_ADC-1:0] fast_overrange_upper_limit,
  input wire logic [8*NUM_ADC-1:0] fast_overrange_lower_limit,
  input wire logic [NUM_ADC-1:0] calibration_run
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before bready");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response changed before rready");
  property p_r_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && (s_axi_rresp == 2'b00 || s_axi_rdata == 32'h00000000);
  endproperty
  a_r_upper_zero: assert property (p_r_upper_zero)
    else $error("read data upper bits not zero");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer missing one cycle after address");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy)
    else $error("write accepted while response pending");
  property p_limit_reset;
    $rose(aresetn) |-> fast_overrange_upper_limit == {NUM_ADC{8'hff}} && fast_overrange_lower_limit == '0;
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("limit reset values wrong");
  property p_loss_reset;
    $rose(aresetn) |-> loss_comp_mode_zero == '1 && loss_comp_modes_one_three == '1
      && loss_comp_modes_four_six_seven == '0 && calibration_run == '0;
  endproperty
  a_loss_reset: assert property (p_loss_reset)
    else $error("gain or calibration reset values wrong");
  property p_limit_change;
    $changed(fast_overrange_upper_limit) || $changed(fast_overrange_lower_limit) |-> s_axi_bvalid;
  endproperty
  a_limit_change: assert property (p_limit_change)
    else $error("limit changed without a write");
  property p_chan_change;
    $changed(oscillator_frequency_word) || $changed(calibration_run) || $changed(loss_comp_mode_zero)
      |-> $past(s_axi_bvalid);
  endproperty
  a_chan_change: assert property (p_chan_change)
    else $error("channel or calibration output changed without a write");
endmodule

bind cddc_regs cddc_regs_chk #(.NUM_CH(NUM_CH), .NUM_ADC(NUM_ADC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .oscillator_frequency_word(oscillator_frequency_word),
  .loss_comp_modes_four_six_seven(loss_comp_modes_four_six_seven),
  .loss_comp_mode_zero(loss_comp_mode_zero), .loss_comp_modes_one_three(loss_comp_modes_one_three),
  .fast_overrange_upper_limit(fast_overrange_upper_limit),
  .fast_overrange_lower_limit(fast_overrange_lower_limit), .calibration_run(calibration_run)
);
`default_nettype wire

// File: channel_ddc_adc_config_regs_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cddc_consts.svh"
module channel_ddc_adc_config_regs_tb_top;
  logic aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_r, w_r, b_v, ar_r, r_v;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, nyq_z, pfb, bsel, sgn, l467, l0, l13;
  logic [1:0] bresp, rresp;
  logic [63:0] word, upl, lol;
  logic [7:0] cal, page;
  logic [7:0] shv [8][8];
  logic [7:0] idx_t [8] = '{8'h07, 8'h08, 8'h2d, 8'h78, 8'h7a, 8'h7b, 8'h7e, 8'hd5};
  logic [7:0] msk_t [8] = '{8'hff, 8'hff, 8'h02, 8'h07, 8'hff, 8'hff, 8'h07, 8'h08};
  logic [7:0] rst_t [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  int mismatches, num_checks, seed;

  cddc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .nyquist_zone_two(nyq_z), .prefilter_band_select(pfb), .band_select_modes_zero_two(bsel),
    .quarter_rate_mix_sign(sgn), .oscillator_frequency_word(word), .loss_comp_modes_four_six_seven(l467),
    .loss_comp_mode_zero(l0), .loss_comp_modes_one_three(l13), .fast_overrange_upper_limit(upl),
    .fast_overrange_lower_limit(lol), .calibration_run(cal));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bready raised after a random lag to exercise response hold
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [3:0] st, output logic [1:0] rs);
    int lag, n;
    logic done;
    logic [31:0] r;
    lag = $unsigned($random(seed)) % 4;
    r = $random(seed);
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= {ix, 2'b00};
    wdata <= {r[31:8], d};
    wstrb <= st;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v && b_r) begin
        rs = bresp;
        b_r <= 1'b0;
        done = 1'b1;
      end else if (n == lag) b_r <= 1'b1;
    end
  endtask

  task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] rs);
    int lag, n;
    logic done;
    lag = $unsigned($random(seed)) % 4;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr <= {ix, 2'b00};
    ar_v <= 1'b1;
    r_r <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v && r_r) begin
        d = rdata;
        rs = rresp;
        r_r <= 1'b0;
        done = 1'b1;
      end else if (n == lag) r_r <= 1'b1;
    end
  endtask

  function automatic logic hit(int k, int c);
    if (k < 2 || k == 7) return page[7] || (c < 3 && page[4+c]);
    return c < 4 && page[c];
  endfunction

  task automatic setpage(input logic [7:0] v);
    logic [1:0] rs;
    logic [31:0] d;
    wr(`CDDC_IDX_PAGE, v, 4'h1, rs);
    chk_resp("page bresp", `CDDC_RESP_OKAY, rs);
    rd(`CDDC_IDX_PAGE, d, rs);
    chk("page rdata", {56'h0, v}, {32'h0, d});
    page = v;
  endtask

  task automatic mwr(input int k, input logic [7:0] d);
    logic [1:0] rs;
    wr(idx_t[k], d, 4'h1, rs);
    chk_resp("bresp", `CDDC_RESP_OKAY, rs);
    for (int c = 0; c < 8; c++) if (hit(k, c)) shv[c][k] = d & msk_t[k];
  endtask

  task automatic mrd(input int k);
    logic [31:0] d;
    logic [1:0] rs;
    int c0;
    c0 = 0;
    for (int c = 7; c >= 0; c--) if (hit(k, c)) c0 = c;
    rd(idx_t[k], d, rs);
    chk_resp("rresp", `CDDC_RESP_OKAY, rs);
    chk("rdata", {56'h0, shv[c0][k]}, {32'h0, d});
  endtask

  // channel outputs lag one edge, so settle two edges first
  task automatic chk_outs();
    logic [27:0] eb;
    logic [63:0] ew, eu, el;
    logic [7:0] ec;
    @(posedge aclk);
    @(negedge aclk);
    for (int c = 0; c < 4; c++) begin
      eb[c] = shv[c][2][1];
      eb[4+c] = shv[c][3][0];
      eb[8+c] = shv[c][3][1];
      eb[12+c] = shv[c][3][2];
      eb[16+c] = shv[c][6][2];
      eb[20+c] = shv[c][6][1];
      eb[24+c] = shv[c][6][0];
      ew[16*c +: 16] = {shv[c][4], shv[c][5]};
    end
    for (int a = 0; a < 8; a++) begin
      eu[8*a +: 8] = shv[a][0];
      el[8*a +: 8] = shv[a][1];
      ec[a] = shv[a][7][3];
    end
    chk("channel bits", {36'h0, eb}, {36'h0, l13, l0, l467, sgn, bsel, pfb, nyq_z});
    chk("freq word", ew, word);
    chk("upper limit", eu, upl);
    chk("lower limit", el, lol);
    chk("calibration", {56'h0, ec}, {56'h0, cal});
  endtask

  // bound: the sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  initial begin
    logic [1:0] rs;
    logic [31:0] d;
    int k;
    seed = 43155;
    mismatches = 0;
    num_checks = 0;
    page = 8'h00;
    {aresetn, aw_v, w_v, b_r, ar_v, r_r} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 56'h0;
    for (int c = 0; c < 8; c++) for (int j = 0; j < 8; j++) shv[c][j] = rst_t[j];
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_outs();
    for (k = 0; k < 8; k++) mrd(k);
    wr(8'h01, 8'h55, 4'h1, rs);
    chk_resp("unmapped bresp", `CDDC_RESP_SLVERR, rs);
    rd(8'h01, d, rs);
    chk_resp("unmapped rresp", `CDDC_RESP_SLVERR, rs);
    chk("unmapped rdata", 64'h0, {32'h0, d});
    mwr(6, 8'h00);
    chk_outs();
    setpage(8'h8f);
    mwr(4, 8'hff);
    mwr(5, 8'hff);
    chk_outs();
    for (k = 2; k < 7; k++) mwr(k, 8'hff);
    chk_outs();
    for (k = 2; k < 7; k++) mrd(k);
    mwr(7, 8'h08);
    chk_outs();
    mwr(7, 8'h00);
    chk_outs();
    wr(idx_t[0], 8'h12, 4'h0, rs);
    chk_resp("no strobe bresp", `CDDC_RESP_OKAY, rs);
    chk_outs();
    repeat (40) begin
      if ($unsigned($random(seed)) % 4 == 0) setpage(8'($random(seed)));
      k = $unsigned($random(seed)) % 8;
      mwr(k, 8'($random(seed)));
      chk_outs();
      mrd(k);
    end
    conclude();
  end
endmodule
`default_nettype wire
